// *** inc/seq_if.sv ***
// Phasor inputs and magnitude results between stage and calculator
`default_nettype none
interface seq_if;
  import seq_pkg::*;
  logic signed [PHASE_W-1:0] phRe    [PHASES];
  logic signed [PHASE_W-1:0] phIm    [PHASES];
  logic        [SEQ_W-1:0]   posMagSq;
  logic        [SEQ_W-1:0]   negMagSq;
  logic        [PH_W-1:0]    phMagSq [PHASES];
  modport calc  (input phRe, phIm, output posMagSq, negMagSq, phMagSq);
  modport stage (output phRe, phIm, input posMagSq, negMagSq, phMagSq);
endinterface
`default_nettype wire

// *** inc/seq_pkg.sv ***
// Constants, types and compare helpers for the sequence voltage stage
`default_nettype none
package seq_pkg;
  // ****************************
  // Widths and encodings
  // ****************************
  localparam int PHASES  = 3;
  localparam int PHASE_W = 16;
  localparam int SUM_W   = PHASE_W + 3;
  localparam int SEQ_W   = 2 * SUM_W + 1;
  localparam int PH_W    = 2 * PHASE_W + 1;
  localparam int LEVEL_W = 14;
  localparam int THR_W   = 40;
  localparam int CMP_W   = 80;
  localparam int ROT_SHIFT = 15;

  typedef enum logic [2:0] {MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF} node_mode_e;
  typedef enum logic [1:0] {FORCE_NORMAL, FORCE_START, FORCE_TRIP, FORCE_BLOCKED} forced_state_e;
  typedef enum logic {SEL_POSITIVE, SEL_NEGATIVE} mag_sel_e;
  typedef enum logic {DIR_OVER, DIR_UNDER} pickup_dir_e;

  // ****************************
  // Levels and ratios
  // ****************************
  localparam logic signed [15:0] ROT_SIN_Q15   = 16'sh6eda;
  localparam logic [LEVEL_W-1:0] LEVEL_UNITY   = 14'h2710;
  localparam logic [LEVEL_W-1:0] PICKUP_RST    = 14'h2904;
  localparam logic [LEVEL_W-1:0] UNDER_BLK_RST = 14'h01f4;
  localparam logic [LEVEL_W-1:0] UNDER_BLK_OFF = 14'h0000;
  localparam logic [6:0]         RATIO_UNITY   = 7'h64;
  localparam logic [6:0]         RELEASE_OVER  = 7'h61;
  localparam logic [6:0]         RELEASE_UNDER = 7'h67;
  localparam logic [CMP_W-1:0]   CMP_SCALE     =
    CMP_W'(LEVEL_UNITY) * CMP_W'(RATIO_UNITY) * CMP_W'(LEVEL_UNITY) * CMP_W'(RATIO_UNITY);

  // Magnitude squared scaled to the threshold domain
  function automatic logic [CMP_W-1:0] lhsSq(input logic [SEQ_W-1:0] magSq);
    return CMP_W'(magSq) * CMP_SCALE;
  endfunction

  // Threshold squared: level (0.01 %) x nominal code x ratio (%)
  function automatic logic [CMP_W-1:0] thrSq(input logic [LEVEL_W-1:0] lvl, input logic [17:0] nomK,
                                             input logic [6:0] num);
    logic [THR_W-1:0] t;
    t = THR_W'(lvl) * THR_W'(nomK) * THR_W'(num);
    return CMP_W'(t) * CMP_W'(t);
  endfunction
endpackage
`default_nettype wire

// *** logic/sequence_calc.sv ***
// Symmetric component calculator: positive, negative and phase magnitudes
`default_nettype none
module sequence_calc
  import seq_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  seq_if.calc       sq
);
  typedef logic signed [SUM_W-1:0] sum_t;
  localparam int PW = PHASE_W + 17;

  sum_t x [PHASES];
  sum_t y [PHASES];
  sum_t xs [PHASES];
  sum_t ys [PHASES];
  sum_t hx [PHASES];
  sum_t hy [PHASES];
  logic [PH_W-1:0] phSq [PHASES];

  // ****************************
  // Per phase rotation terms
  // ****************************
  for (genvar i = 0; i < PHASES; i++) begin : g_ph
    logic signed [PW-1:0] px;
    logic signed [PW-1:0] py;
    logic signed [2*PHASE_W-1:0] sr;
    logic signed [2*PHASE_W-1:0] si;
    // Fundamental phasors only; harmonics never reach this block
    assign x[i]  = SUM_W'(sq.phRe[i]);
    assign y[i]  = SUM_W'(sq.phIm[i]);
    assign px    = PW'(sq.phRe[i]) * PW'(ROT_SIN_Q15);
    assign py    = PW'(sq.phIm[i]) * PW'(ROT_SIN_Q15);
    assign xs[i] = SUM_W'(px >>> ROT_SHIFT);
    assign ys[i] = SUM_W'(py >>> ROT_SHIFT);
    assign hx[i] = x[i] >>> 1;
    assign hy[i] = y[i] >>> 1;
    assign sr    = (2*PHASE_W)'(sq.phRe[i]) * (2*PHASE_W)'(sq.phRe[i]);
    assign si    = (2*PHASE_W)'(sq.phIm[i]) * (2*PHASE_W)'(sq.phIm[i]);
    assign phSq[i] = PH_W'($unsigned(sr)) + PH_W'($unsigned(si));
  end

  // ****************************
  // Three times the sequence phasors
  // ****************************
  // Rotation by 120: (-x/2 - y*s, x*s - y/2); by 240: (-x/2 + y*s, -x*s - y/2)
  sum_t posRe;
  sum_t posIm;
  sum_t negRe;
  sum_t negIm;
  assign posRe = x[0] + (-hx[1] - ys[1]) + (-hx[2] + ys[2]);
  assign posIm = y[0] + (xs[1] - hy[1]) + (-xs[2] - hy[2]);
  assign negRe = x[0] + (-hx[1] + ys[1]) + (-hx[2] - ys[2]);
  assign negIm = y[0] + (-xs[1] - hy[1]) + (xs[2] - hy[2]);

  function automatic logic [SEQ_W-1:0] magSq(input sum_t re, input sum_t im);
    logic signed [2*SUM_W-1:0] a;
    logic signed [2*SUM_W-1:0] b;
    a = (2*SUM_W)'(re) * (2*SUM_W)'(re);
    b = (2*SUM_W)'(im) * (2*SUM_W)'(im);
    return SEQ_W'($unsigned(a)) + SEQ_W'($unsigned(b));
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sq.posMagSq <= '0;
      sq.negMagSq <= '0;
      sq.phMagSq  <= '{default: '0};
    end else begin
      sq.posMagSq <= magSq(posRe, posIm);
      sq.negMagSq <= magSq(negRe, negIm);
      sq.phMagSq  <= phSq;
    end
  end

  // All-zero phasors give zero sequence results
  logic balancedIn;
  assign balancedIn = (sq.phRe[0] == '0) && (sq.phIm[0] == '0) && (sq.phRe[1] == '0) &&
                      (sq.phIm[1] == '0) && (sq.phRe[2] == '0) && (sq.phIm[2] == '0);
  zero_in_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    balancedIn |=> sq.posMagSq == '0 && sq.negMagSq == '0)
    else $error("zero phasors give nonzero sequence magnitude");
endmodule
`default_nettype wire

// *** logic/sequence_voltage_stage.sv ***
// Sequence voltage protection stage: pick-up, hysteresis, blocking, forcing
`default_nettype none
// Notes on behaviour
// - Positive sequence is a third of U1 + a*U2 + a^2*U3.
// - Negative sequence is a third of U1 + a^2*U2 + a*U3.
// - Only fundamental phasors feed the sequence calculation.
// - Static select picks positive or negative magnitude; positive by default.
// - Node mode On, Blocked, Test, Test/Blocked, Off; only when globally enabled.
// - With forcing enabled, status forced to Normal, Start, Trip or Blocked.
// - Mode, force and magnitude select stay static across setting groups.
// - Over mode releases only below 97 percent of pick-up.
// - Under mode releases only above 103 percent of pick-up.
// - Pick-up when magnitude goes above (over) or below (under) the level.
// - Direction setting selects over or under; over by default.
// - Pick-up level in 0.01 percent steps, default 105 percent.
// - Under-block level in percent of nominal, default 5, used in under mode.
// - In under mode trip is suppressed while voltage is below block level.
// - Under-block holds until every phase voltage exceeds pick-up level.
// - Block level zero disables under-block.
// - Group settings apply live, without restarting the stage.
// - Pick-up gives start unless block input active or node mode Blocked/Test-Blocked; then blocked only.
// - Instant operation: trip in the same cycle as start.
module sequence_voltage_stage
  import seq_pkg::*;
#(
  parameter logic [15:0] NOMINAL_CODE = 16'h4000
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      progTick,
  input  wire logic signed [PHASE_W-1:0] phaseRe [PHASES],
  input  wire logic signed [PHASE_W-1:0] phaseIm [PHASES],
  input  wire logic                      blockIn,
  input  wire logic                      nodeModeEnable,
  input  wire logic                      forceEnable,
  input  wire logic                      staticLoad,
  input  wire node_mode_e                nodeModeSet,
  input  wire forced_state_e             forcedStateSet,
  input  wire mag_sel_e                  magSelSet,
  input  wire pickup_dir_e               pickupDir,
  input  wire logic [LEVEL_W-1:0]        pickupLevel,
  input  wire logic [LEVEL_W-1:0]        underBlockLevel,
  output logic                           startOut,
  output logic                           tripOut,
  output logic                           blockedOut,
  output logic                           pickupOut,
  output logic                           underBlockActive,
  output logic                           testActive,
  output logic [SEQ_W-1:0]               supervisedMagnitude
);
  localparam logic [17:0] NOM1 = 18'(NOMINAL_CODE);
  localparam logic [17:0] NOM3 = 18'(NOMINAL_CODE) * 18'h3;

  // ****************************
  // Sequence calculation
  // ****************************
  seq_if sq ();
  assign sq.phRe = phaseRe;
  assign sq.phIm = phaseIm;

  sequence_calc u_calc (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .sq      (sq.calc)
  );

  // ****************************
  // Static settings
  // ****************************
  node_mode_e    nodeMode_q;
  forced_state_e forced_q;
  mag_sel_e      magSel_q;

  // Loaded only by their own strobe, never by group changes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nodeMode_q <= MODE_ON;
      forced_q   <= FORCE_NORMAL;
      magSel_q   <= SEL_POSITIVE;
    end else if (staticLoad) begin
      nodeMode_q <= nodeModeSet;
      forced_q   <= forcedStateSet;
      magSel_q   <= magSelSet;
    end
  end

  logic modeOff;
  logic modeBlk;
  assign modeOff = nodeModeEnable && nodeMode_q == MODE_OFF;
  assign modeBlk = nodeModeEnable && (nodeMode_q == MODE_BLOCKED || nodeMode_q == MODE_TEST_BLOCKED);
  assign testActive = nodeModeEnable && (nodeMode_q == MODE_TEST || nodeMode_q == MODE_TEST_BLOCKED);

  // ****************************
  // Comparisons
  // ****************************
  logic [SEQ_W-1:0] supMag;
  logic [CMP_W-1:0] lhs;
  logic aboveSet;
  logic belowSet;
  logic belowRel;
  logic aboveRel;
  logic belowBlk;
  logic isUnder;

  assign supMag   = (magSel_q == SEL_NEGATIVE) ? sq.negMagSq : sq.posMagSq;
  assign lhs      = lhsSq(supMag);
  // Live group levels: a change takes effect at the next evaluation
  assign aboveSet = lhs > thrSq(pickupLevel, NOM3, RATIO_UNITY);
  assign belowSet = lhs < thrSq(pickupLevel, NOM3, RATIO_UNITY);
  assign belowRel = lhs < thrSq(pickupLevel, NOM3, RELEASE_OVER);
  assign aboveRel = lhs > thrSq(pickupLevel, NOM3, RELEASE_UNDER);
  assign belowBlk = lhs < thrSq(underBlockLevel, NOM3, RATIO_UNITY);
  assign isUnder  = pickupDir == DIR_UNDER;

  logic [PHASES-1:0] phAbove;
  for (genvar i = 0; i < PHASES; i++) begin : g_ph
    assign phAbove[i] = lhsSq(SEQ_W'(sq.phMagSq[i])) > thrSq(pickupLevel, NOM1, RATIO_UNITY);
  end

  // ****************************
  // Pick-up and under-block
  // ****************************
  logic pickup_d;
  logic underBlk_d;
  logic blkEff;
  logic start_d;

  always_comb begin
    if (isUnder) begin
      pickup_d = pickupOut ? !aboveRel : belowSet;
    end else begin
      pickup_d = pickupOut ? !belowRel : aboveSet;
    end
  end

  always_comb begin
    if (!isUnder || underBlockLevel == UNDER_BLK_OFF) begin
      underBlk_d = 1'b0;
    end else begin
      underBlk_d = underBlockActive ? !(&phAbove) : belowBlk;
    end
  end

  assign blkEff  = blockIn || modeBlk;
  assign start_d = pickup_d && !blkEff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pickupOut        <= 1'b0;
      underBlockActive <= 1'b0;
    end else if (progTick) begin
      pickupOut        <= pickup_d && !modeOff;
      underBlockActive <= underBlk_d && !modeOff;
    end
  end

  // ****************************
  // Status outputs
  // ****************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      startOut   <= 1'b0;
      tripOut    <= 1'b0;
      blockedOut <= 1'b0;
    end else if (progTick) begin
      if (forceEnable) begin
        startOut   <= forced_q == FORCE_START || forced_q == FORCE_TRIP;
        tripOut    <= forced_q == FORCE_TRIP;
        blockedOut <= forced_q == FORCE_BLOCKED;
      end else if (modeOff) begin
        startOut   <= 1'b0;
        tripOut    <= 1'b0;
        blockedOut <= 1'b0;
      end else begin
        startOut   <= start_d;
        tripOut    <= start_d && !underBlk_d;
        blockedOut <= pickup_d && blkEff;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      supervisedMagnitude <= '0;
    end else if (progTick) begin
      supervisedMagnitude <= supMag;
    end
  end

  // ****************************
  // Assertions
  // ****************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  tick_hold_a: assert property (!progTick |=> $stable(startOut) && $stable(tripOut) && $stable(pickupOut))
    else $error("outputs changed without a program tick");
  instant_trip_a: assert property (tripOut |-> startOut)
    else $error("trip without start");
  start_blocked_a: assert property (!(startOut && blockedOut))
    else $error("start and blocked together");
  block_wins_a: assert property (progTick && blockIn && !forceEnable |=> !startOut)
    else $error("start despite block input");
  over_pickup_a: assert property (progTick && !isUnder && aboveSet && !modeOff |=> pickupOut)
    else $error("over pick-up missed");
  over_hold_a: assert property (progTick && pickupOut && !isUnder && !belowRel && !modeOff |=> pickupOut)
    else $error("over release above 97 percent");
  under_hold_a: assert property (progTick && pickupOut && isUnder && !aboveRel && !modeOff |=> pickupOut)
    else $error("under release below 103 percent");
  zero_block_a: assert property (progTick && underBlockLevel == UNDER_BLK_OFF |=> !underBlockActive)
    else $error("under-block with zero level");
  uv_no_trip_a: assert property (underBlockActive && !forceEnable |-> !tripOut)
    else $error("trip during under-block");
  uv_hold_a: assert property (progTick && underBlockActive && isUnder && !(&phAbove)
    && underBlockLevel != UNDER_BLK_OFF && !modeOff |=> underBlockActive)
    else $error("under-block released early");
  forced_trip_a: assert property (progTick && forceEnable && forced_q == FORCE_TRIP |=> tripOut && startOut)
    else $error("forced trip not shown");
  off_quiet_a: assert property (progTick && !forceEnable && modeOff |=> !startOut && !tripOut && !pickupOut)
    else $error("activity in off mode");
  static_hold_a: assert property (!staticLoad |=> $stable(magSel_q) && $stable(nodeMode_q))
    else $error("static setting changed without load");

  // ****************************
  // Pick-up and release edges
  // ****************************
  under_pickup_a: assert property (
    progTick && isUnder && belowSet && !modeOff |=> pickupOut)
    else $error("under pick-up missed");
  over_release_a: assert property (
    progTick && pickupOut && !isUnder && belowRel && !modeOff |=> !pickupOut)
    else $error("over pick-up not released");
  under_release_a: assert property (
    progTick && pickupOut && isUnder && aboveRel && !modeOff |=> !pickupOut)
    else $error("under pick-up not released");

  // ****************************
  // Under-block engage and scope
  // ****************************
  uv_engage_a: assert property (
    progTick && isUnder && !underBlockActive && belowBlk && underBlockLevel != UNDER_BLK_OFF
    && !modeOff |=> underBlockActive)
    else $error("under-block not engaged");
  over_no_block_a: assert property (
    progTick && !isUnder |=> !underBlockActive)
    else $error("under-block in over mode");

  // ****************************
  // Forced states
  // ****************************
  forced_start_a: assert property (
    progTick && forceEnable && forced_q == FORCE_START |=> startOut && !tripOut && !blockedOut)
    else $error("forced start not shown");
  forced_normal_a: assert property (
    progTick && forceEnable && forced_q == FORCE_NORMAL |=> !startOut && !tripOut && !blockedOut)
    else $error("forced normal not quiet");
  forced_block_a: assert property (
    progTick && forceEnable && forced_q == FORCE_BLOCKED |=> blockedOut && !startOut && !tripOut)
    else $error("forced blocked not shown");

  // ****************************
  // Blocking and mode
  // ****************************
  blocked_pick_a: assert property (
    progTick && !forceEnable && !modeOff && pickup_d && blkEff |=> blockedOut)
    else $error("blocked output missing");
  mode_block_a: assert property (
    progTick && !forceEnable && modeBlk |=> !startOut)
    else $error("start in blocked mode");
  test_mode_a: assert property (
    testActive |-> nodeModeEnable)
    else $error("test flag without node mode");
  start_trip_a: assert property (
    progTick && !forceEnable && !modeOff && !underBlk_d |=> tripOut == startOut)
    else $error("trip not instant with start");

  // ****************************
  // Supervised magnitude
  // ****************************
  neg_select_a: assert property (
    progTick && magSel_q == SEL_NEGATIVE |=> supervisedMagnitude == $past(sq.negMagSq))
    else $error("negative magnitude not supervised");
  pos_select_a: assert property (
    progTick && magSel_q == SEL_POSITIVE |=> supervisedMagnitude == $past(sq.posMagSq))
    else $error("positive magnitude not supervised");
  mag_hold_a: assert property (
    !progTick |=> $stable(supervisedMagnitude))
    else $error("magnitude changed without a program tick");

  trip_seen_c: cover property (progTick && !forceEnable ##1 tripOut);
  blocked_seen_c: cover property (blockedOut && !forceEnable);
  uv_block_c: cover property ($rose(underBlockActive));
  release_c: cover property ($fell(pickupOut));
  test_trip_c: cover property (progTick && testActive ##1 tripOut);
endmodule
`default_nettype wire

// *** test/phasor_source.sv ***
// Front-end model: balanced fundamental phasor sets for the stage
`default_nettype none
module phasor_source
  import seq_pkg::*;
(
  input  wire logic [15:0]          amp,
  input  wire logic                 negSet,
  output logic signed [PHASE_W-1:0] phRe [PHASES],
  output logic signed [PHASE_W-1:0] phIm [PHASES]
);
  timeunit 1ns;
  timeprecision 1ps;
  int half;
  int sinPart;
  // Pure fundamental phasors, no harmonic content
  always_comb begin
    half = int'(amp) / 2;
    sinPart = (int'(amp) * 28378) >>> 15;
    if (negSet) begin
      sinPart = -sinPart;
    end
    phRe[0] = PHASE_W'(amp);
    phIm[0] = '0;
    phRe[1] = PHASE_W'(-half);
    phIm[1] = PHASE_W'(-sinPart);
    phRe[2] = PHASE_W'(-half);
    phIm[2] = PHASE_W'(sinPart);
  end
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the sequence voltage stage
`default_nettype none
module tb
  import seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] NOM = 16'h4000;
  logic ref_clk, rst_n, progTick, blockIn, nodeModeEnable, forceEnable, staticLoad, negSet;
  node_mode_e nodeModeSet;
  forced_state_e forcedStateSet;
  mag_sel_e magSelSet;
  pickup_dir_e pickupDir;
  logic [LEVEL_W-1:0] pickupLevel, underBlockLevel;
  logic [15:0] amp;
  logic signed [PHASE_W-1:0] phRe [PHASES];
  logic signed [PHASE_W-1:0] phIm [PHASES];
  logic startOut, tripOut, blockedOut, pickupOut, underBlockActive, testActive;
  logic [SEQ_W-1:0] supervisedMagnitude;
  int n_mismatch = 0;
  int checks_done = 0;

  phasor_source src_u (.amp(amp), .negSet(negSet), .phRe(phRe), .phIm(phIm));
  sequence_voltage_stage #(.NOMINAL_CODE(NOM)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .progTick(progTick), .phaseRe(phRe), .phaseIm(phIm),
    .blockIn(blockIn), .nodeModeEnable(nodeModeEnable), .forceEnable(forceEnable),
    .staticLoad(staticLoad), .nodeModeSet(nodeModeSet), .forcedStateSet(forcedStateSet),
    .magSelSet(magSelSet), .pickupDir(pickupDir), .pickupLevel(pickupLevel),
    .underBlockLevel(underBlockLevel), .startOut(startOut), .tripOut(tripOut),
    .blockedOut(blockedOut), .pickupOut(pickupOut), .underBlockActive(underBlockActive),
    .testActive(testActive), .supervisedMagnitude(supervisedMagnitude));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ****************************
  // Helpers
  // ****************************
  function automatic logic [15:0] pct(input int p);
    return 16'(int'(NOM) * p / 100);
  endfunction

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Flags: pickup, start, trip, blocked, under-block, test
  task automatic chkBits(input string nm, input logic [5:0] exp);
    logic [5:0] got;
    got = {pickupOut, startOut, tripOut, blockedOut, underBlockActive, testActive};
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
      n_mismatch++;
    end
  endtask

  // Squared 3x sequence magnitude, small rounding allowed
  task automatic chkMag(input string nm, input longint a3);
    longint d;
    checks_done++;
    d = longint'(supervisedMagnitude) - a3 * a3;
    if ($isunknown(supervisedMagnitude) || d > a3 * 64 || d < -a3 * 64) begin
      $display("[FAIL] %s expected %0d seen %0d", nm, a3 * a3, supervisedMagnitude);
      n_mismatch++;
    end
  endtask

  // Phasors one cycle ahead, then one program tick
  task automatic tick(input int p);
    amp = pct(p);
    @(negedge ref_clk);
    progTick = 1'b1;
    @(negedge ref_clk);
    progTick = 1'b0;
  endtask

  task automatic setStatic(input node_mode_e m, input forced_state_e f, input mag_sel_e s);
    nodeModeSet = m;
    forcedStateSet = f;
    magSelSet = s;
    staticLoad = 1'b1;
    @(negedge ref_clk);
    staticLoad = 1'b0;
    @(negedge ref_clk);
  endtask

  // ****************************
  // Scenarios
  // ****************************
  task automatic sOver();
    tick(110); chkBits("over pickup", 6'b111000);
    chkMag("pos mag", 3 * longint'(pct(110)));
    tick(103); chkBits("over hold", 6'b111000);
    tick(100); chkBits("over release", 6'b000000);
    tick(104); chkBits("over below", 6'b000000);
    pickupLevel = LEVEL_UNITY;
    tick(104); chkBits("live level", 6'b111000);
    pickupLevel = PICKUP_RST;
    tick(100); chkBits("level back", 6'b000000);
  endtask

  task automatic sNeg();
    setStatic(MODE_ON, FORCE_NORMAL, SEL_NEGATIVE);
    tick(110); chkBits("neg on pos set", 6'b000000);
    negSet = 1'b1;
    tick(110); chkBits("neg pickup", 6'b111000);
    chkMag("neg mag", 3 * longint'(pct(110)));
    tick(100);
    negSet = 1'b0;
    setStatic(MODE_ON, FORCE_NORMAL, SEL_POSITIVE);
  endtask

  task automatic sUnder();
    pickupDir = DIR_UNDER;
    tick(100); chkBits("under pickup", 6'b111000);
    tick(107); chkBits("under hold", 6'b111000);
    tick(2); chkBits("under block", 6'b110010);
    tick(100); chkBits("block holds", 6'b110010);
    tick(110); chkBits("under release", 6'b000000);
    underBlockLevel = UNDER_BLK_OFF;
    tick(2); chkBits("block off", 6'b111000);
    underBlockLevel = UNDER_BLK_RST;
    pickupDir = DIR_OVER;
    tick(100);
  endtask

  task automatic sBlock();
    blockIn = 1'b1;
    tick(110); chkBits("blocked", 6'b100100);
    blockIn = 1'b0;
    tick(110); chkBits("unblocked", 6'b111000);
    blockIn = 1'b1;
    tick(110); chkBits("block in start", 6'b100100);
    blockIn = 1'b0;
    tick(100);
  endtask

  task automatic sForce();
    logic [5:0] exp [4] = '{6'b000000, 6'b010000, 6'b011000, 6'b000100};
    forceEnable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      setStatic(MODE_ON, forced_state_e'(i), SEL_POSITIVE);
      tick(100); chkBits("forced", exp[i]);
    end
    setStatic(MODE_ON, FORCE_TRIP, SEL_POSITIVE);
    forcedStateSet = FORCE_NORMAL;
    tick(100); chkBits("force static", 6'b011000);
    forceEnable = 1'b0;
    setStatic(MODE_ON, FORCE_NORMAL, SEL_POSITIVE);
  endtask

  task automatic sMode();
    logic [5:0] exp [4] = '{6'b000000, 6'b100100, 6'b111001, 6'b100101};
    node_mode_e md [4] = '{MODE_OFF, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED};
    nodeModeEnable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      setStatic(md[i], FORCE_NORMAL, SEL_POSITIVE);
      tick(110); chkBits("node mode", exp[i]);
    end
    nodeModeEnable = 1'b0;
    tick(110); chkBits("mode disabled", 6'b111000);
    setStatic(MODE_ON, FORCE_NORMAL, SEL_POSITIVE);
    tick(100);
  endtask

  // ****************************
  // Main sequence
  // ****************************
  initial begin
    rst_n = 1'b0; progTick = 1'b0; blockIn = 1'b0; nodeModeEnable = 1'b0;
    forceEnable = 1'b0; staticLoad = 1'b0; negSet = 1'b0; amp = 16'h0000;
    nodeModeSet = MODE_ON; forcedStateSet = FORCE_NORMAL; magSelSet = SEL_POSITIVE;
    pickupDir = DIR_OVER; pickupLevel = PICKUP_RST; underBlockLevel = UNDER_BLK_RST;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    chkBits("reset", 6'b000000);
    sOver();
    sNeg();
    sUnder();
    sBlock();
    sForce();
    sMode();
    conclude();
  end

  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
